//--- hdl/srclk_defs.svh
// Register offsets, field positions and reset values of the sensor
// reference clocking block.
// Assumes 8-bit register pointers and 16-bit registers.
`ifndef SRCLK_DEFS_SVH
`define SRCLK_DEFS_SVH

`define SRCLK_ADDR_DIV0 8'h14
`define SRCLK_ADDR_DIV1 8'h15
`define SRCLK_ADDR_DIV2 8'h16
`define SRCLK_ADDR_DIV3 8'h17
`define SRCLK_ADDR_SETUP 8'h1A
`define SRCLK_ADDR_MUX 8'h1B

`define SRCLK_REG_RST 16'h0000
// Idle levels of the filtered pins: the two bus wires high, the rest low.
`define SRCLK_PIN_IDLE 8'h03

`define SRCLK_REFDIV_MSB 9
`define SRCLK_REFDIV_LSB 0
`define SRCLK_FINSEL_MSB 13
`define SRCLK_FINSEL_LSB 12
`define SRCLK_CLKSEL_BIT 9
`define SRCLK_ACTCH_MSB 15
`define SRCLK_ACTCH_LSB 14
`define SRCLK_AUTOSCAN_BIT 15
`define SRCLK_RRSEQ_MSB 14
`define SRCLK_RRSEQ_LSB 13

`define SRCLK_FIN_DIV2 2'h2
`define SRCLK_RR_TWO 2'h0
`define SRCLK_RR_THREE 2'h1

// Arbitrary bus address of the device.
`define SRCLK_I2C_ADDR 7'h2A
`define SRCLK_BYTE_BITS 4'h8
`define SRCLK_LAST_BIT 4'h7

`define SRCLK_PIN_SCL 0
`define SRCLK_PIN_SDA 1
`define SRCLK_PIN_EXT 2
`define SRCLK_PIN_INT 3
`define SRCLK_PIN_SNS 4

`endif

//--- hdl/srclk_pkg.sv
// Types shared by the sensor reference clocking block.
// Assumes the constants of srclk_defs.svh.
package srclk_pkg;

   typedef enum logic [4:0]
   {
      I2C_IDLE = 5'h01,
      I2C_RX = 5'h02,
      I2C_AOUT = 5'h04,
      I2C_TX = 5'h08,
      I2C_AIN = 5'h10
   } srclk_i2c_st_t;

   typedef struct packed
   {
      logic [1:0] chan;
      logic ref_tick;
      logic fin_tick;
   } srclk_meas_clk_t;

endpackage

//--- hdl/srclk_div.sv
// Event divider: one output pulse for every ratio input pulses.
// Assumes tick_in is a one-cycle pulse on the same clock.
`timescale 1ns/100ps
module srclk_div #(parameter int W = 10)
(
   // Clock and reset.
   input wire logic clock,
   input wire logic sys_rst,
   // Events to divide and the ratio.
   input wire logic tick_in,
   input wire logic [W-1:0] ratio,
   // Divided event.
   output logic tick_ff
);

   logic [W-1:0] cnt_ff;
   logic [W-1:0] nxt_cnt;
   logic wrap;

   // A ratio of zero acts as one, so a cleared register never stalls.
   assign nxt_cnt = cnt_ff + {{(W-1){1'b0}}, 1'b1};
   assign wrap = (nxt_cnt >= ratio);

   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         cnt_ff <= '0;
         tick_ff <= 1'b0;
      end
      else
      begin
         tick_ff <= tick_in && wrap;
         if (tick_in)
            cnt_ff <= wrap ? '0 : nxt_cnt;
      end
   end

endmodule

//--- hdl/srclk_top.sv
// Clock source select, per-channel dividers, channel sequencer and the
// register slave of the sensor reference clocking block.
// Assumes oscillators and pins are asynchronous and slower than clock/4,
// and that the measurement core pulses conv_done at each channel's end.
//
// Overview of operation
// - Master clock comes from on-chip oscillator or external clock pin.
// - Setup bit 9 at 0x1A: 0 on-chip oscillator, 1 external clock.
// - Channel reference clock is master clock over its 10-bit ratio.
// - Channel input clock is sensor frequency over its divide select.
// - Multi-channel mode steps through the active channels in turn.
// - Single-channel mode measures only the selected channel.
// - All clock fields are written and read over the I2C port.
`timescale 1ns/100ps
`include "srclk_defs.svh"
module srclk_top
(
   // Clock and reset.
   input wire logic clock,
   input wire logic sys_rst,
   // Two-wire register port.
   input wire logic scl_pin,
   input wire logic sda_pin_in,
   output logic sda_pin_out_ff,
   output logic sda_pin_oe_ff,
   // Clock sources.
   input wire logic int_osc_pin,
   input wire logic external_clock_pin,
   input wire logic [3:0] sensor_osc_pin,
   // Measurement core.
   input wire logic conv_done,
   output srclk_pkg::srclk_meas_clk_t meas_clk_ff
);

   ////////////////////////////////////////////////////////////////////
   logic [7:0] pin_raw;
   logic [7:0] sync1_ff;
   logic [7:0] sync2_ff;
   logic [7:0] sync3_ff;
   logic [7:0] filt_ff;
   logic [7:0] prev_ff;
   logic [7:0] agree;
   logic [7:0] rise;
   logic [7:0] fall;

   assign pin_raw = {sensor_osc_pin, int_osc_pin, external_clock_pin,
                     sda_pin_in, scl_pin};
   assign agree = ~(sync2_ff ^ sync3_ff);
   assign rise = filt_ff & ~prev_ff;
   assign fall = ~filt_ff & prev_ff;

   // A level is accepted only once two late stages agree; this rejects
   // short glitches at the cost of two cycles of latency.
   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         // Every stage starts at the idle level, so no false edge follows.
         sync1_ff <= `SRCLK_PIN_IDLE;
         sync2_ff <= `SRCLK_PIN_IDLE;
         sync3_ff <= `SRCLK_PIN_IDLE;
         filt_ff <= `SRCLK_PIN_IDLE;
         prev_ff <= `SRCLK_PIN_IDLE;
      end
      else
      begin
         sync1_ff <= pin_raw;
         sync2_ff <= sync1_ff;
         sync3_ff <= sync2_ff;
         filt_ff <= (sync3_ff & agree) | (filt_ff & ~agree);
         prev_ff <= filt_ff;
      end
   end

   ////////////////////////////////////////////////////////////////////
   logic [15:0] div_ff [4];
   logic [15:0] setup_ff;
   logic [15:0] mux_ff;
   logic [7:0] ptr_ff;
   logic [7:0] wr_hi_ff;
   logic [7:0] sh_ff;
   logic [15:0] rd_word;
   logic wr_strobe;

   always_comb
   begin
      case (ptr_ff)
         `SRCLK_ADDR_DIV0: rd_word = div_ff[0];
         `SRCLK_ADDR_DIV1: rd_word = div_ff[1];
         `SRCLK_ADDR_DIV2: rd_word = div_ff[2];
         `SRCLK_ADDR_DIV3: rd_word = div_ff[3];
         `SRCLK_ADDR_SETUP: rd_word = setup_ff;
         `SRCLK_ADDR_MUX: rd_word = mux_ff;
         default: rd_word = 16'h0000;
      endcase
   end

   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         for (int i = 0; i < 4; i++)
            div_ff[i] <= `SRCLK_REG_RST;
         setup_ff <= `SRCLK_REG_RST;
         mux_ff <= `SRCLK_REG_RST;
      end
      else if (wr_strobe)
      begin
         case (ptr_ff)
            `SRCLK_ADDR_DIV0: div_ff[0] <= {wr_hi_ff, sh_ff};
            `SRCLK_ADDR_DIV1: div_ff[1] <= {wr_hi_ff, sh_ff};
            `SRCLK_ADDR_DIV2: div_ff[2] <= {wr_hi_ff, sh_ff};
            `SRCLK_ADDR_DIV3: div_ff[3] <= {wr_hi_ff, sh_ff};
            `SRCLK_ADDR_SETUP: setup_ff <= {wr_hi_ff, sh_ff};
            `SRCLK_ADDR_MUX: mux_ff <= {wr_hi_ff, sh_ff};
            default: ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   srclk_pkg::srclk_i2c_st_t st_ff;
   logic [3:0] bitcnt_ff;
   logic [1:0] bytecnt_ff;
   logic rw_ff;
   logic rd_lo_ff;
   logic nack_ff;
   logic scl_hi;
   logic i2c_start;
   logic i2c_stop;
   logic scl_rise;
   logic scl_fall;
   logic byte_done;
   logic [7:0] nxt_tx_byte;

   assign scl_hi = filt_ff[`SRCLK_PIN_SCL];
   assign scl_rise = rise[`SRCLK_PIN_SCL];
   assign scl_fall = fall[`SRCLK_PIN_SCL];
   assign i2c_start = scl_hi && fall[`SRCLK_PIN_SDA] && !scl_rise;
   assign i2c_stop = scl_hi && rise[`SRCLK_PIN_SDA] && !scl_rise;
   assign byte_done = (st_ff == srclk_pkg::I2C_RX) && scl_fall
                      && (bitcnt_ff == `SRCLK_BYTE_BITS);
   assign wr_strobe = byte_done && !rw_ff && (bytecnt_ff == 2'h3);
   assign nxt_tx_byte = rd_lo_ff ? rd_word[7:0] : rd_word[15:8];

   // Only low is ever driven; the enable alone shapes the open-drain line.
   always_ff @(posedge clock)
   begin
      if (sys_rst)
         sda_pin_out_ff <= 1'b0;
      else
         sda_pin_out_ff <= 1'b0;
   end

   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         st_ff <= srclk_pkg::I2C_IDLE;
         bitcnt_ff <= 4'h0;
         bytecnt_ff <= 2'h0;
         sh_ff <= 8'h00;
         rw_ff <= 1'b0;
         rd_lo_ff <= 1'b0;
         nack_ff <= 1'b0;
         ptr_ff <= 8'h00;
         wr_hi_ff <= 8'h00;
         sda_pin_oe_ff <= 1'b0;
      end
      else if (i2c_start)
      begin
         st_ff <= srclk_pkg::I2C_RX;
         bitcnt_ff <= 4'h0;
         bytecnt_ff <= 2'h0;
         sda_pin_oe_ff <= 1'b0;
      end
      else if (i2c_stop)
      begin
         st_ff <= srclk_pkg::I2C_IDLE;
         sda_pin_oe_ff <= 1'b0;
      end
      else
      begin
         case (st_ff)
            srclk_pkg::I2C_RX:
            begin
               if (scl_rise)
               begin
                  sh_ff <= {sh_ff[6:0], filt_ff[`SRCLK_PIN_SDA]};
                  bitcnt_ff <= bitcnt_ff + 4'h1;
               end
               else if (byte_done)
               begin
                  bitcnt_ff <= 4'h0;
                  if (bytecnt_ff == 2'h0 && sh_ff[7:1] != `SRCLK_I2C_ADDR)
                     st_ff <= srclk_pkg::I2C_IDLE;
                  else
                  begin
                     st_ff <= srclk_pkg::I2C_AOUT;
                     sda_pin_oe_ff <= 1'b1;
                  end
                  if (bytecnt_ff == 2'h0)
                     rw_ff <= sh_ff[0];
                  if (bytecnt_ff == 2'h1)
                     ptr_ff <= sh_ff;
                  if (bytecnt_ff == 2'h2)
                     wr_hi_ff <= sh_ff;
                  bytecnt_ff <= (bytecnt_ff == 2'h3) ? 2'h2
                                : bytecnt_ff + 2'h1;
               end
            end
            srclk_pkg::I2C_AOUT:
            begin
               if (scl_fall && rw_ff && bytecnt_ff == 2'h1)
               begin
                  st_ff <= srclk_pkg::I2C_TX;
                  sh_ff <= rd_word[15:8];
                  sda_pin_oe_ff <= ~rd_word[15];
                  rd_lo_ff <= 1'b1;
               end
               else if (scl_fall)
               begin
                  st_ff <= srclk_pkg::I2C_RX;
                  sda_pin_oe_ff <= 1'b0;
               end
            end
            srclk_pkg::I2C_TX:
            begin
               if (scl_fall && bitcnt_ff == `SRCLK_LAST_BIT)
               begin
                  st_ff <= srclk_pkg::I2C_AIN;
                  bitcnt_ff <= 4'h0;
                  sda_pin_oe_ff <= 1'b0;
               end
               else if (scl_fall)
               begin
                  sh_ff <= {sh_ff[6:0], 1'b0};
                  sda_pin_oe_ff <= ~sh_ff[6];
                  bitcnt_ff <= bitcnt_ff + 4'h1;
               end
            end
            srclk_pkg::I2C_AIN:
            begin
               if (scl_rise)
                  nack_ff <= filt_ff[`SRCLK_PIN_SDA];
               else if (scl_fall && nack_ff)
                  st_ff <= srclk_pkg::I2C_IDLE;
               else if (scl_fall)
               begin
                  st_ff <= srclk_pkg::I2C_TX;
                  sh_ff <= nxt_tx_byte;
                  sda_pin_oe_ff <= ~nxt_tx_byte[7];
                  rd_lo_ff <= ~rd_lo_ff;
               end
            end
            default:
               st_ff <= srclk_pkg::I2C_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   logic clk_sel;
   logic mst_tick_ff;
   logic [3:0] ref_tick;
   logic [3:0] fin_tick;

   assign clk_sel = setup_ff[`SRCLK_CLKSEL_BIT];

   // One master clock feeds every channel's reference divider.
   always_ff @(posedge clock)
   begin
      if (sys_rst)
         mst_tick_ff <= 1'b0;
      else
         mst_tick_ff <= clk_sel ? rise[`SRCLK_PIN_EXT]
                                : rise[`SRCLK_PIN_INT];
   end

   for (genvar c = 0; c < 4; c++)
   begin : g_chan
      srclk_div #(.W(10)) u_ref
      (
         .clock(clock),
         .sys_rst(sys_rst),
         .tick_in(mst_tick_ff),
         .ratio(div_ff[c][`SRCLK_REFDIV_MSB:`SRCLK_REFDIV_LSB]),
         .tick_ff(ref_tick[c])
      );
      srclk_div #(.W(2)) u_fin
      (
         .clock(clock),
         .sys_rst(sys_rst),
         .tick_in(rise[`SRCLK_PIN_SNS + c]),
         .ratio((div_ff[c][`SRCLK_FINSEL_MSB:`SRCLK_FINSEL_LSB]
                 == `SRCLK_FIN_DIV2) ? 2'h2 : 2'h1),
         .tick_ff(fin_tick[c])
      );
   end

   ////////////////////////////////////////////////////////////////////
   logic autoscan;
   logic [1:0] single_sel;
   logic [1:0] rr_seq;
   logic [1:0] last_ch;
   logic [1:0] seq_ff;

   assign autoscan = mux_ff[`SRCLK_AUTOSCAN_BIT];
   assign single_sel = setup_ff[`SRCLK_ACTCH_MSB:`SRCLK_ACTCH_LSB];
   assign rr_seq = mux_ff[`SRCLK_RRSEQ_MSB:`SRCLK_RRSEQ_LSB];
   assign last_ch = (rr_seq == `SRCLK_RR_TWO) ? 2'h1
                    : (rr_seq == `SRCLK_RR_THREE) ? 2'h2 : 2'h3;

   always_ff @(posedge clock)
   begin
      if (sys_rst)
         seq_ff <= 2'h0;
      else if (!autoscan)
         seq_ff <= single_sel;
      else if (seq_ff > last_ch)
         seq_ff <= 2'h0;
      else if (conv_done)
         seq_ff <= (seq_ff == last_ch) ? 2'h0 : seq_ff + 2'h1;
   end

   // Other channels' clocks never reach the core.
   always_ff @(posedge clock)
   begin
      if (sys_rst)
         meas_clk_ff <= '0;
      else
      begin
         meas_clk_ff.chan <= seq_ff;
         meas_clk_ff.ref_tick <= ref_tick[seq_ff];
         meas_clk_ff.fin_tick <= fin_tick[seq_ff];
      end
   end

   ////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clock); endclocking
   default disable iff (sys_rst);

   AST_SRC_INT: assert property (
      !clk_sel && rise[`SRCLK_PIN_INT] |=> mst_tick_ff)
      else $error("internal oscillator edge lost");
   AST_SRC_EXT: assert property (
      clk_sel && rise[`SRCLK_PIN_EXT] |=> mst_tick_ff)
      else $error("external clock edge lost");
   AST_SRC_ONE: assert property (
      mst_tick_ff |-> $past(clk_sel ? rise[`SRCLK_PIN_EXT]
                                    : rise[`SRCLK_PIN_INT]))
      else $error("master tick from unselected source");
   AST_REF_BY1: assert property (
      div_ff[0][9:0] == 10'h001 && $stable(div_ff[0]) && mst_tick_ff
      |=> ref_tick[0])
      else $error("ratio one did not pass every master tick");
   AST_REF_GAP: assert property (
      ref_tick[0] && div_ff[0][9:0] > 10'h001 && $stable(div_ff[0])
      |=> !ref_tick[0])
      else $error("reference ticks closer than ratio");
   AST_FIN_BY1: assert property (
      div_ff[1][13:12] == 2'h1 && rise[`SRCLK_PIN_SNS + 1]
      |=> fin_tick[1])
      else $error("divide by one lost a sensor edge");
   AST_SINGLE: assert property (
      !autoscan && $past(!autoscan) |-> seq_ff == $past(single_sel))
      else $error("single mode left selected channel");
   AST_MULTI: assert property (
      autoscan && conv_done && seq_ff < last_ch && $stable(mux_ff)
      |=> seq_ff == $past(seq_ff) + 2'h1 ##1 meas_clk_ff.chan == $past(seq_ff))
      else $error("sequencer did not advance");
   AST_WRAP: assert property (
      autoscan && conv_done && seq_ff == last_ch |=> seq_ff == 2'h0)
      else $error("sequencer did not wrap");
   AST_ROUTE: assert property (
      meas_clk_ff.ref_tick |-> $past(ref_tick[seq_ff]))
      else $error("foreign reference tick reached core");
   AST_WRITE: assert property (
      wr_strobe && ptr_ff == `SRCLK_ADDR_SETUP
      |=> setup_ff == $past({wr_hi_ff, sh_ff}))
      else $error("setup write lost");

   COV_EXT: cover property (clk_sel && mst_tick_ff);
   COV_WRAP: cover property (autoscan && conv_done && seq_ff == 2'h3);
   COV_READ: cover property (st_ff == srclk_pkg::I2C_AIN && rd_lo_ff);
   COV_FIN2: cover property (div_ff[0][13:12] == 2'h2 && fin_tick[0]);

endmodule

//--- sim/srclk_host.sv
// Host model: a two-wire master that writes and reads the block's registers.
// Assumes a pull-up on SDA; sda_low high means the host pulls SDA low.
`timescale 1ns/100ps
`include "srclk_defs.svh"
module srclk_host
(
   // Clock.
   input wire logic clock,
   // Bus wires.
   input wire logic sda_wire,
   output logic scl_pin,
   output logic sda_low
);
   // Eight clocks a phase keeps every level far above the pin filter depth.
   localparam int Q = 8;

   initial
   begin
      scl_pin = 1'b1;
      sda_low = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic ph(input logic s, input logic d);
   begin
      repeat (Q) @(posedge clock);
      scl_pin <= s;
      sda_low <= d;
   end
   endtask

   // Data moves only while SCL is low, so no bit looks like START or STOP.
   task automatic bit_x(input logic b, output logic r);
   begin
      ph(1'b0, sda_low);
      ph(1'b0, ~b);
      ph(1'b1, ~b);
      repeat (Q) @(posedge clock);
      r = sda_wire;
   end
   endtask

   task automatic cond(input logic stop);
   begin
      ph(1'b0, sda_low);
      ph(1'b0, stop);
      ph(1'b1, stop);
      ph(1'b1, ~stop);
   end
   endtask

   task automatic wbyte(input logic [7:0] v, inout logic ok);
      logic r;
   begin
      for (int i = 7; i >= 0; i--)
         bit_x(v[i], r);
      bit_x(1'b1, r);
      ok = ok & ~r;
   end
   endtask

   task automatic rbyte(input logic last, output logic [7:0] v);
      logic r;
   begin
      for (int i = 7; i >= 0; i--)
      begin
         bit_x(1'b1, r);
         v[i] = r;
      end
      bit_x(last, r);
   end
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Register write, high byte first.
   task automatic wr(input logic [7:0] p, input logic [15:0] d,
      output logic ok);
   begin
      ok = 1'b1;
      cond(1'b0);
      wbyte({`SRCLK_I2C_ADDR, 1'b0}, ok);
      wbyte(p, ok);
      wbyte(d[15:8], ok);
      wbyte(d[7:0], ok);
      cond(1'b1);
   end
   endtask

   // Register read through a repeated start.
   task automatic rd(input logic [7:0] p, output logic [15:0] d,
      output logic ok);
   begin
      ok = 1'b1;
      cond(1'b0);
      wbyte({`SRCLK_I2C_ADDR, 1'b0}, ok);
      wbyte(p, ok);
      cond(1'b0);
      wbyte({`SRCLK_I2C_ADDR, 1'b1}, ok);
      rbyte(1'b0, d[15:8]);
      rbyte(1'b1, d[7:0]);
      cond(1'b1);
   end
   endtask
endmodule

//--- sim/sensor_reference_clocking_bench.sv
// Bench of the sensor reference clocking block: registers, clock source,
// dividers and the channel sequencer.
// Assumes the host model of srclk_host.sv on the two-wire port.
`timescale 1ns/100ps
`include "srclk_defs.svh"
module sensor_reference_clocking_bench;
   localparam int W = 2400;
   logic clock, sys_rst, scl_pin, host_low, sda_wire, sda_out, sda_oe;
   logic int_osc_pin, external_clock_pin, conv_done;
   logic [3:0] sensor_osc_pin;
   srclk_pkg::srclk_meas_clk_t meas;
   int failures, checked, seed, cyc, ref_cnt, fin_cnt, r0, f0, n, e, last;
   int sp [4] = '{100, 104, 110, 120};
   logic [7:0] addr [7] = '{8'h14, 8'h15, 8'h16, 8'h17, 8'h1A, 8'h1B, 8'h20};
   logic [15:0] v;
   logic [1:0] s;

   assign sda_wire = ~(host_low | (sda_oe & ~sda_out));

   srclk_top dut (.clock(clock), .sys_rst(sys_rst), .scl_pin(scl_pin),
      .sda_pin_in(sda_wire), .sda_pin_out_ff(sda_out),
      .sda_pin_oe_ff(sda_oe), .int_osc_pin(int_osc_pin),
      .external_clock_pin(external_clock_pin),
      .sensor_osc_pin(sensor_osc_pin), .conv_done(conv_done),
      .meas_clk_ff(meas));

   srclk_host host (.clock(clock), .sda_wire(sda_wire), .scl_pin(scl_pin),
      .sda_low(host_low));

   ////////////////////////////////////////////////////////////////////////
   task automatic tally_and_finish();
   begin
      $display("checks %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   end
   endtask

   task automatic chk(input string nm, input logic [15:0] ex,
      input logic [15:0] g);
   begin
      checked++;
      if (g !== ex)
      begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", nm, ex, g);
      end
   end
   endtask

   // Tick counts may land one off, depending on window phase.
   function automatic logic [15:0] near(input int ex, input int g);
      return (g >= ex - 1 && g <= ex + 1) ? ex[15:0] : g[15:0];
   endfunction

   function automatic int ticks(input int period, input int div);
      return W / (period * div);
   endfunction

   task automatic wreg(input logic [7:0] p, input logic [15:0] d);
      logic ok;
   begin
      host.wr(p, d, ok);
      chk("write ack", 16'h0001, {15'h0000, ok});
   end
   endtask

   task automatic rreg(input logic [7:0] p, input logic [15:0] ex);
      logic ok;
      logic [15:0] g;
   begin
      host.rd(p, g, ok);
      chk("read ack", 16'h0001, {15'h0000, ok});
      chk("register", ex, g);
   end
   endtask

   // The core here is a bare strobe; the settle and count phases that the
   // host sizes per channel are left out of the gaps.
   task automatic pulse();
   begin
      @(posedge clock);
      conv_done <= 1'b1;
      @(posedge clock);
      conv_done <= 1'b0;
      repeat (3) @(posedge clock);
   end
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end

   always @(posedge clock)
   begin
      cyc++;
      int_osc_pin <= (cyc % 8) < 4;
      external_clock_pin <= (cyc % 12) < 6;
      for (int i = 0; i < 4; i++)
         sensor_osc_pin[i] <= (cyc % sp[i]) < sp[i] / 2;
      if (meas.ref_tick === 1'b1)
         ref_cnt++;
      if (meas.fin_tick === 1'b1)
         fin_cnt++;
      if (cyc == 95000)
      begin
         failures++;
         tally_and_finish();
      end
   end

   initial
   begin
      seed = 32'hA485F9CA;
      conv_done = 1'b0;
      sys_rst = 1'b1;
      repeat (10) @(posedge clock);
      sys_rst <= 1'b0;
      repeat (8) @(posedge clock);
      chk("sda out", 16'h0000, {15'h0000, sda_out});
      chk("sda enable", 16'h0000, {15'h0000, sda_oe});
      foreach (addr[i])
         rreg(addr[i], 16'h0000);
      $display("test reset values done");
      foreach (addr[i])
      begin
         v = $random(seed);
         wreg(addr[i], v);
         rreg(addr[i], (i == 6) ? 16'h0000 : v);
      end
      $display("test register access done");
      wreg(8'h1B, 16'h0000);
      for (int c = 0; c < 4; c++)
      begin
         n = 1 + ($random(seed) & 1);
         s = c[1] ? 2'h2 : 2'h1;
         wreg(8'(8'h14 + c), {2'h0, s, 2'h0, n[9:0]});
         wreg(8'h1A, {c[1:0], 4'h0, c[0], 9'h000});
         repeat (8) @(posedge clock);
         chk("chan", 16'(c), {14'h0000, meas.chan});
         pulse();
         chk("chan held", 16'(c), {14'h0000, meas.chan});
         repeat (64) @(posedge clock);
         r0 = ref_cnt;
         f0 = fin_cnt;
         repeat (W) @(posedge clock);
         e = ticks(c[0] ? 12 : 8, n);
         chk("ref ticks", 16'(e), near(e, ref_cnt - r0));
         e = ticks(sp[c], c[1] ? 2 : 1);
         chk("fin ticks", 16'(e), near(e, fin_cnt - f0));
      end
      $display("test clock sources and dividers done");
      // The last setup write left channel 3 selected.
      e = 3;
      for (int rr = 0; rr < 4; rr++)
      begin
         wreg(8'h1B, {1'b1, rr[1:0], 13'h0000});
         last = (rr == 0) ? 1 : (rr == 1) ? 2 : 3;
         if (e > last)
            e = 0;
         for (int k = 0; k < 7; k++)
         begin
            e = (e == last) ? 0 : e + 1;
            pulse();
            chk("sequence", 16'(e), {14'h0000, meas.chan});
         end
      end
      $display("test channel sequencing done");
      tally_and_finish();
   end
endmodule
